/* File: spi_flags_top.v */
// status flags, data buffers and apb slave of a serial port
// assumes apb master on CLK_I; link pins are asynchronous
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "spi_consts.vh"

module spi_flags_top #(
  parameter HALF_DIV = `SCK_HALF_DIV
) (
  // clock and reset
  input  wire        CLK_I,
  input  wire        RESET_I,
  // apb slave
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [7:0]  PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output wire        PREADY_O,
  output reg         PSLVERR_O,
  // interrupt
  output wire        IRQ_O,
  // serial clock
  input  wire        SCK_I,
  output wire        SCK_O,
  output wire        SCK_OE_O,
  // master out slave in
  input  wire        MOSI_I,
  output wire        MOSI_O,
  output wire        MOSI_OE_O,
  // master in slave out
  input  wire        MISO_I,
  output wire        MISO_O,
  output wire        MISO_OE_O,
  // slave select
  input  wire        SS_N_I,
  output reg         SS_N_O,
  output wire        SS_N_OE_O
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg  [3:0] meta_q;
  reg  [3:0] sync_q;
  reg        ss_prev_q;

  always @(posedge CLK_I) begin
    if (RESET_I) begin
      // idle levels: select high, clock low, no false edge
      meta_q    <= 4'h8;
      sync_q    <= 4'h8;
      ss_prev_q <= 1'b1;
    end else begin
      meta_q    <= {SS_N_I, SCK_I, MOSI_I, MISO_I};
      sync_q    <= meta_q;
      ss_prev_q <= sync_q[3];
    end
  end

  wire ss_s   = sync_q[3];
  wire sck_s  = sync_q[2];
  wire mosi_s = sync_q[1];
  wire miso_s = sync_q[0];

  // ----------------------------------------------------------------
  // state declarations
  // ----------------------------------------------------------------
  reg  [7:0] ctrl1_q;
  reg  [7:0] ctrl2_q;
  reg  [3:0] irq_st_q;
  reg  [3:0] irq_en_q;
  reg        rf_q;
  reg        rf_arm_q;
  reg        tx_full_q;
  reg        te_arm_q;
  reg        mf_q;
  reg        mf_arm_q;
  reg  [7:0] tx_buf_q;
  reg  [7:0] rx_buf_q;
  reg  [31:0] rdata_d;
  reg        err_d;

  wire       master  = ctrl1_q[`C1_MASTER_SELECT];
  wire       txie    = ctrl1_q[`C1_TXIE];
  wire       soe     = ctrl1_q[`C1_SOE];
  wire       fden    = ctrl2_q[`C2_FDEN];
  wire       te_flag = ~tx_full_q;
  wire [7:0] flags;

  // unused bits stay zero
  assign flags = {rf_q, 1'b0, te_flag, mf_q, 4'h0};

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire setup = PSEL_I & ~PENABLE_I;
  wire acc   = PSEL_I & PENABLE_I;
  wire wr    = acc & PWRITE_I;
  wire rd    = acc & ~PWRITE_I;

  wire hit_c1  = (PADDR_I == `OFS_CTRL1);
  wire hit_c2  = (PADDR_I == `OFS_CTRL2);
  wire hit_fl  = (PADDR_I == `OFS_FLAGS);
  wire hit_dat = (PADDR_I == `OFS_DATA);
  wire hit_ist = (PADDR_I == `OFS_IRQ_STAT);
  wire hit_icl = (PADDR_I == `OFS_IRQ_CLR);
  wire hit_ien = (PADDR_I == `OFS_IRQ_EN);

  wire wr_c1  = wr & hit_c1;
  wire wr_c2  = wr & hit_c2;
  wire wr_dat = wr & hit_dat;
  wire wr_icl = wr & hit_icl;
  wire wr_ien = wr & hit_ien;
  wire rd_fl  = rd & hit_fl;
  wire rd_dat = rd & hit_dat;

  assign PREADY_O = 1'b1;

  // read data is captured in the setup cycle
  always @* begin
    rdata_d = 32'h00000000;
    err_d   = 1'b0;
    case (1'b1)
      hit_c1:  rdata_d[7:0] = ctrl1_q;
      hit_c2:  rdata_d[7:0] = ctrl2_q;
      hit_fl:  rdata_d[7:0] = flags;
      hit_dat: rdata_d[7:0] = rx_buf_q;
      hit_ist: rdata_d[3:0] = irq_st_q;
      hit_icl: rdata_d[3:0] = 4'h0;
      hit_ien: rdata_d[3:0] = irq_en_q;
      default: err_d = 1'b1;
    endcase
  end

  always @(posedge CLK_I) begin
    if (RESET_I) begin
      PRDATA_O  <= 32'h00000000;
      PSLVERR_O <= 1'b0;
    end else if (setup) begin
      PRDATA_O  <= rdata_d;
      PSLVERR_O <= err_d;
    end
  end

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  wire       sh_ready;
  wire       sh_done;
  wire       sh_busy;
  wire [7:0] sh_rx;
  wire       sh_sdo;
  wire       sh_sck;
  wire       fault;
  wire       load;

  // fault input only in master, fault detect on, output off
  assign fault = master & fden & ~soe & ~ss_s & ss_prev_q;

  // queued byte moves as soon as the shifter is free
  assign load = tx_full_q & sh_ready;

  spi_shifter #(
    .HALF_DIV    (HALF_DIV)
  ) u_shifter (
    .clk_i       (CLK_I),
    .rst_i       (RESET_I),
    .master_i    (master),
    .abort_i     (fault),
    .load_i      (load),
    .load_data_i (tx_buf_q),
    .ready_o     (sh_ready),
    .done_o      (sh_done),
    .rx_data_o   (sh_rx),
    .busy_o      (sh_busy),
    .sck_s_i     (sck_s),
    .ss_n_s_i    (ss_s),
    .sdi_s_i     (master ? miso_s : mosi_s),
    .sck_o       (sh_sck),
    .sdo_o       (sh_sdo)
  );

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  assign SCK_O     = sh_sck;
  assign SCK_OE_O  = master;
  assign MOSI_O    = sh_sdo;
  assign MOSI_OE_O = master;
  assign MISO_O    = sh_sdo;
  assign MISO_OE_O = ~master & ~ss_s;
  assign SS_N_OE_O = master & fden & soe;

  always @(posedge CLK_I) begin
    if (RESET_I) begin
      SS_N_O <= 1'b1;
    end else begin
      SS_N_O <= ~(master & (sh_busy | tx_full_q | ~sh_ready));
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      ctrl1_q <= `RST_CTRL1;
      ctrl2_q <= `RST_CTRL2;
    end else begin
      if (wr_c1) begin
        ctrl1_q <= PWDATA_I[7:0];
      end
      // fault drops to slave, over any write
      if (fault) begin
        ctrl1_q[`C1_MASTER_SELECT] <= 1'b0;
      end
      if (wr_c2) begin
        ctrl2_q <= PWDATA_I[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // receive full flag and buffer
  // ----------------------------------------------------------------
  wire rf_clr  = rd_dat & rf_arm_q;
  wire overrun = sh_done & rf_q & ~rf_clr;
  wire rx_take = sh_done & ~overrun;

  always @(posedge CLK_I) begin
    if (RESET_I) begin
      rf_q     <= 1'b0;
      rf_arm_q <= 1'b0;
      rx_buf_q <= `RST_BYTE;
    end else begin
      if (rx_take) begin
        rx_buf_q <= sh_rx;
      end
      // a new byte wins over the clear
      if (rx_take) begin
        rf_q <= 1'b1;
      end else if (rf_clr) begin
        rf_q <= 1'b0;
      end
      if (rd_fl && PRDATA_O[`FL_RF]) begin
        rf_arm_q <= 1'b1;
      end else if (rd_dat) begin
        rf_arm_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit empty flag and buffer
  // ----------------------------------------------------------------
  wire tx_acc = wr_dat & te_arm_q & ~tx_full_q;

  always @(posedge CLK_I) begin
    if (RESET_I) begin
      tx_full_q <= 1'b0;
      te_arm_q  <= 1'b0;
      tx_buf_q  <= `RST_BYTE;
    end else begin
      if (tx_acc) begin
        tx_buf_q  <= PWDATA_I[7:0];
        tx_full_q <= 1'b1;
      end else if (load) begin
        tx_full_q <= 1'b0;
      end
      if (rd_fl && PRDATA_O[`FL_TE]) begin
        te_arm_q <= 1'b1;
      end else if (wr_dat) begin
        te_arm_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode fault flag
  // ----------------------------------------------------------------
  wire mf_clr = wr_c1 & mf_arm_q;

  always @(posedge CLK_I) begin
    if (RESET_I) begin
      mf_q     <= 1'b0;
      mf_arm_q <= 1'b0;
    end else begin
      if (fault) begin
        mf_q <= 1'b1;
      end else if (mf_clr) begin
        mf_q <= 1'b0;
      end
      if (rd_fl && PRDATA_O[`FL_MF]) begin
        mf_arm_q <= 1'b1;
      end else if (wr_c1) begin
        mf_arm_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, clear and enable
  // ----------------------------------------------------------------
  wire [3:0] ev;

  assign ev[`EV_RF]  = rx_take;
  assign ev[`EV_TE]  = load;
  assign ev[`EV_MF]  = fault;
  assign ev[`EV_OVR] = overrun;

  always @(posedge CLK_I) begin
    if (RESET_I) begin
      irq_st_q <= `RST_IRQ;
      irq_en_q <= `RST_IRQ;
    end else begin
      // set wins over clear
      if (wr_icl) begin
        irq_st_q <= (irq_st_q & ~PWDATA_I[3:0]) | ev;
      end else begin
        irq_st_q <= irq_st_q | ev;
      end
      if (wr_ien) begin
        irq_en_q <= PWDATA_I[3:0];
      end
    end
  end

  // level request from events or empty buffer
  assign IRQ_O = (|(irq_st_q & irq_en_q)) | (te_flag & txie);

endmodule // spi_flags_top

/* File: spi_consts.vh */
// constants of the serial flags and data buffer block
// assumes a 32-bit apb register bus with byte addresses
`ifndef SPI_CONSTS_VH
`define SPI_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL1     8'h00
`define OFS_CTRL2     8'h04
`define OFS_FLAGS     8'h08
`define OFS_DATA      8'h0C
`define OFS_IRQ_STAT  8'h10
`define OFS_IRQ_CLR   8'h14
`define OFS_IRQ_EN    8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FL_RF         7
`define FL_TE         5
`define FL_MF         4
`define C1_TXIE       5
`define C1_MASTER_SELECT       4
`define C1_SOE        1
`define C2_FDEN       4
`define EV_RF         0
`define EV_TE         1
`define EV_MF         2
`define EV_OVR        3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CTRL1     8'h00
`define RST_CTRL2     8'h00
`define RST_IRQ       4'h0
`define RST_BYTE      8'h00

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define TEF_SET_CYC   2
`define SCK_HALF_DIV  4

`endif

/* File: spi_shifter.v */
// eight-bit serial shift engine, master or slave, clock mode 0
// assumes link inputs already pass a two-stage synchroniser
`timescale 1ns/100ps
`include "spi_consts.vh"

module spi_shifter #(
  parameter HALF_DIV = `SCK_HALF_DIV
) (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // control
  input  wire       master_i,
  input  wire       abort_i,
  input  wire       load_i,
  input  wire [7:0] load_data_i,
  output wire       ready_o,
  output reg        done_o,
  output reg  [7:0] rx_data_o,
  output wire       busy_o,
  // synchronised link
  input  wire       sck_s_i,
  input  wire       ss_n_s_i,
  input  wire       sdi_s_i,
  output reg        sck_o,
  output wire       sdo_o
);

  localparam [7:0] DIV_LAST = HALF_DIV[7:0] - 8'h01;

  reg       have_q;
  reg       busy_q;
  reg [7:0] sh_q;
  reg       smp_q;
  reg [2:0] cnt_q;
  reg [7:0] div_q;
  reg       sck_prev_q;

  wire rise = sck_s_i & ~sck_prev_q;
  wire fall = ~sck_s_i & sck_prev_q;

  assign ready_o = ~have_q & ~busy_q;
  assign busy_o  = busy_q;
  assign sdo_o   = sh_q[7];

  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      have_q     <= 1'b0;
      busy_q     <= 1'b0;
      sh_q       <= `RST_BYTE;
      smp_q      <= 1'b0;
      cnt_q      <= 3'h0;
      div_q      <= 8'h00;
      sck_prev_q <= 1'b0;
      sck_o      <= 1'b0;
      rx_data_o  <= `RST_BYTE;
    end else if (abort_i) begin
      have_q <= 1'b0;
      busy_q <= 1'b0;
      cnt_q  <= 3'h0;
      sck_o  <= 1'b0;
    end else begin
      sck_prev_q <= sck_s_i;
      if (load_i) begin
        sh_q   <= load_data_i;
        have_q <= 1'b1;
      end
      if (master_i) begin
        if (!busy_q) begin
          div_q <= 8'h00;
          if (have_q) begin
            busy_q <= 1'b1;
          end
        end else if (div_q == DIV_LAST) begin
          div_q <= 8'h00;
          sck_o <= ~sck_o;
          if (!sck_o) begin
            smp_q <= sdi_s_i;
          end else begin
            sh_q  <= {sh_q[6:0], smp_q};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              busy_q    <= 1'b0;
              have_q    <= 1'b0;
              done_o    <= 1'b1;
              rx_data_o <= {sh_q[6:0], smp_q};
            end
          end
        end else begin
          div_q <= div_q + 8'h01;
        end
      end else begin
        sck_o <= 1'b0;
        if (ss_n_s_i) begin
          cnt_q  <= 3'h0;
          busy_q <= 1'b0;
        end else if (rise) begin
          smp_q  <= sdi_s_i;
          busy_q <= 1'b1;
        end else if (fall && busy_q) begin
          sh_q  <= {sh_q[6:0], smp_q};
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == 3'h7) begin
            busy_q    <= 1'b0;
            have_q    <= 1'b0;
            done_o    <= 1'b1;
            rx_data_o <= {sh_q[6:0], smp_q};
          end
        end
      end
    end
  end

endmodule // spi_shifter

/* File: spi_link_partner.sv */
// behavioural far-end slave on the serial link, clock mode 0
// assumes the design is master and holds select low per frame
`timescale 1ns/100ps

module spi_link_partner (
  // link
  input  wire       sck_i,
  input  wire       ss_n_i,
  input  wire       mosi_i,
  output reg        miso_o,
  // reply and capture
  input  wire [7:0] reply_i,
  output reg  [7:0] got_o
);
  reg [7:0] sh_q;
  reg [2:0] n_q;
  reg       odd_q;

  initial begin
    miso_o = 1'h1;
    got_o = 8'h00;
  end
  // first bit out as soon as selected
  always @(negedge ss_n_i) begin
    n_q = 3'h0;
    odd_q = 1'h0;
    sh_q = reply_i;
    miso_o = sh_q[7];
  end
  always @(posedge sck_i)
    if (!ss_n_i)
      got_o = {got_o[6:0], mosi_i};
  // second byte of a frame answers inverted
  always @(negedge sck_i)
    if (!ss_n_i) begin
      n_q = n_q + 3'h1;
      if (n_q == 3'h0) begin
        odd_q = ~odd_q;
        sh_q = odd_q ? ~reply_i : reply_i;
      end else
        sh_q = {sh_q[6:0], 1'h0};
      miso_o = sh_q[7];
    end
  // released line must not keep its value
  always @(posedge ss_n_i)
    miso_o = ~miso_o;
endmodule // spi_link_partner

/* File: spi_flags_monitor.sv */
// port checks of the serial flags block
// assumes HALF_DIV of 4 or less and a zero-wait apb slave
`timescale 1ns/100ps
`include "spi_consts.vh"

module spi_flags_monitor (
  // clock and reset
  input wire        CLK_I,
  input wire        RESET_I,
  // apb
  input wire        PSEL_I,
  input wire        PENABLE_I,
  input wire        PWRITE_I,
  input wire [7:0]  PADDR_I,
  input wire [31:0] PWDATA_I,
  input wire [31:0] PRDATA_O,
  input wire        PREADY_O,
  input wire        PSLVERR_O,
  // irq and link
  input wire        IRQ_O,
  input wire        SCK_O,
  input wire        SS_N_O
);
  wire setup;
  reg  txie_q;

  assign setup = PSEL_I && !PENABLE_I;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // shadow of the transmit irq enable
  always @(posedge CLK_I)
    if (RESET_I)
      txie_q <= 1'h0;
    else if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == `OFS_CTRL1)
      txie_q <= PWDATA_I[`C1_TXIE];

  a_ready_high: assert property (PREADY_O)
    else $error("ready low");
  a_unmapped_err: assert property (setup && PADDR_I == 8'h1C |=> PSLVERR_O)
    else $error("no error on unmapped address");
  a_flags_unused: assert property (setup && PADDR_I == `OFS_FLAGS
    |=> PRDATA_O[31:8] == 24'h0 && !PRDATA_O[6] && PRDATA_O[3:0] == 4'h0)
    else $error("unused flag bits set");
  a_reset_idle: assert property ($fell(RESET_I)
    |-> SS_N_O && !SCK_O && !IRQ_O)
    else $error("not idle after reset");
  a_start_clock: assert property ($fell(SS_N_O) |-> ##[1:20] SCK_O)
    else $error("no clock after select");
  a_sck_framed: assert property (SS_N_O |-> !SCK_O)
    else $error("clock outside frame");
  a_irq_txie: assert property (setup && PADDR_I == `OFS_FLAGS
    ##1 PRDATA_O[`FL_TE] && txie_q |-> IRQ_O)
    else $error("no irq with empty flag");
  a_rdata_stands: assert property (!setup |=> $stable(PRDATA_O))
    else $error("read data moved");
endmodule // spi_flags_monitor

bind spi_flags_top spi_flags_monitor spi_flags_monitor_i (.*);

/* File: spi_flags_top_test.sv */
// self-checking bench of the serial flags block
// assumes the link partner model as far-end slave
`timescale 1ns/100ps
`include "spi_consts.vh"

module spi_flags_top_test;
  reg         clk, rst, psel, pen, pwr, ss_n, e;
  reg  [7:0]  paddr, reply, cap;
  reg         sck_d, mosi_d;
  wire        miso_out, sck_oe, mosi_oe, miso_oe, ss_oe;
  reg  [31:0] pwd, r;
  wire [31:0] prd;
  wire        prdy, perr, irq, sck, mosi, miso, ssno;
  wire [7:0]  got;
  integer     miscompares, samples_checked, n;

  spi_flags_top #(.HALF_DIV(4)) spi_flags_top_i (
    .CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(prdy), .PSLVERR_O(perr), .IRQ_O(irq), .SCK_I(sck_d),
    .SCK_O(sck), .SCK_OE_O(sck_oe), .MOSI_I(mosi_d), .MOSI_O(mosi),
    .MOSI_OE_O(mosi_oe), .MISO_I(miso), .MISO_O(miso_out),
    .MISO_OE_O(miso_oe), .SS_N_I(ss_n), .SS_N_O(ssno),
    .SS_N_OE_O(ss_oe));
  spi_link_partner spi_link_partner_i (.sck_i(sck), .ss_n_i(ssno),
    .mosi_i(mosi), .miso_o(miso), .reply_i(reply), .got_o(got));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // ----
  // tasks
  // ----
  task test_done;
    begin
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  task chk(input [31:0] g, input [31:0] x);
    begin
      samples_checked = samples_checked + 1;
      if (g !== x) begin
        miscompares = miscompares + 1;
        $display("mismatch at %0t got %h exp %h", $time, g, x);
      end
    end
  endtask

  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'h1;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (prdy !== 1'h1 && n < 16);
      r = prd;
      e = perr;
      if (prdy !== 1'h1) begin
        miscompares = miscompares + 1;
        test_done;
      end
      psel <= 1'h0;
      pen <= 1'h0;
      @(posedge clk);
    end
  endtask

  task rd(input [7:0] a, input [31:0] x);
    begin
      apb(1'h0, a, 32'h0);
      chk(r, x);
    end
  endtask

  // far-end master frame, link clock period 400 ns
  task slv(input [7:0] b);
    integer i;
    begin
      ss_n <= 1'h0;
      repeat (4) @(posedge clk);
      chk({28'h0, ss_oe, miso_oe, sck_oe, mosi_oe}, 32'h4);
      for (i = 7; i >= 0; i = i - 1) begin
        mosi_d <= b[i];
        repeat (4) @(posedge clk);
        sck_d <= 1'h1;
        cap = {cap[6:0], miso_out};
        repeat (4) @(posedge clk);
        sck_d <= 1'h0;
      end
      repeat (4) @(posedge clk);
      ss_n <= 1'h1;
      @(posedge clk);
    end
  endtask

  task wait_idle;
    begin
      n = 0;
      while (ssno !== 1'h1 && n < 400) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n == 400) begin
        miscompares = miscompares + 1;
        test_done;
      end
      repeat (2) @(posedge clk);
    end
  endtask

  // ----
  // tests
  // ----
  initial begin
    miscompares = 0;
    samples_checked = 0;
    {rst, psel, pen, pwr, ss_n} = 5'h19;
    {paddr, pwd, reply} = {8'h00, 32'h0, 8'h96};
    {sck_d, mosi_d, cap} = 10'h000;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd(`OFS_FLAGS, 32'h20);
    rd(`OFS_DATA, 32'h0);
    apb(1'h0, 8'h1C, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'h1, `OFS_FLAGS, 32'hFF);
    rd(`OFS_FLAGS, 32'h20);
    $display("test reset_map done");
    apb(1'h1, `OFS_CTRL1, 32'h10);
    chk({28'h0, ss_oe, miso_oe, sck_oe, mosi_oe}, 32'h3);
    rd(`OFS_FLAGS, 32'h20);
    apb(1'h1, `OFS_DATA, 32'hA5);
    rd(`OFS_FLAGS, 32'h20);
    apb(1'h1, `OFS_DATA, 32'h3C);
    rd(`OFS_FLAGS, 32'h0);
    apb(1'h1, `OFS_DATA, 32'hFF);
    wait_idle;
    chk({24'h0, got}, 32'h3C);
    rd(`OFS_DATA, 32'h96);
    rd(`OFS_FLAGS, 32'hA0);
    rd(`OFS_DATA, 32'h96);
    rd(`OFS_FLAGS, 32'h20);
    $display("test transfer done");
    rd(`OFS_IRQ_STAT, 32'hB);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, `OFS_IRQ_EN, 32'h8);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, `OFS_IRQ_CLR, 32'h8);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, `OFS_CTRL1, 32'h30);
    rd(`OFS_FLAGS, 32'h20);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, `OFS_CTRL1, 32'h10);
    chk({31'h0, irq}, 32'h0);
    $display("test irq done");
    ss_n <= 1'h0;
    repeat (6) @(posedge clk);
    rd(`OFS_FLAGS, 32'h20);
    ss_n <= 1'h1;
    apb(1'h1, `OFS_CTRL2, 32'h10);
    ss_n <= 1'h0;
    repeat (6) @(posedge clk);
    ss_n <= 1'h1;
    apb(1'h1, `OFS_CTRL1, 32'h10);
    rd(`OFS_FLAGS, 32'h30);
    apb(1'h1, `OFS_CTRL1, 32'h10);
    rd(`OFS_FLAGS, 32'h20);
    $display("test fault done");
    apb(1'h1, `OFS_CTRL1, 32'h00);
    rd(`OFS_FLAGS, 32'h20);
    apb(1'h1, `OFS_DATA, 32'h5A);
    slv(8'hC3);
    chk({24'h0, cap}, 32'h5A);
    rd(`OFS_FLAGS, 32'hA0);
    rd(`OFS_DATA, 32'hC3);
    rd(`OFS_FLAGS, 32'h20);
    $display("test slave done");
    test_done;
  end
endmodule // spi_flags_top_test
